// ==== logic/jlps_param_set.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "jlps_defines.svh"
module jlps_param_set #(
   parameter int MAX_LANES = 8
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   input  wire logic                   sync_req_n,
   output logic                        ilas_active,
   output logic                        cfg_insert,
   output logic                        data_active,
   output logic                        encoding_64b66b,
   output logic [9:0]                  serdes_rate_x32,
   output logic [8:0]                  frames_per_mf,
   output logic [MAX_LANES-1:0]        lane_enable,
   output logic [MAX_LANES*5-1:0]      lane_id,
   output logic [MAX_LANES*8-1:0]      lane_chksum
);
   typedef struct packed {
      logic                          link_en;
      logic                          scr_cfg;
      logic [3:0]                    link_operating_mode_select;
      logic [7:0]                    frames_per_multiframe_minus_one;
      logic [7:0]                    did_cfg;
      jlps_pkg::jlps_mode_t          act;
      logic [8:0]                    k;
      logic [7:0]                    did;
      logic                          scr;
      logic [MAX_LANES-1:0][7:0]     chk;
      logic [MAX_LANES-1:0]          lane_en;
      jlps_pkg::jlps_link_state_t    lst;
      logic [10:0]                   cnt;
      logic                          cfg_ins;
      logic [31:0]                   rdata;
   } jlps_state_t;

   jlps_state_t q;
   jlps_state_t d;

   function automatic jlps_pkg::jlps_mode_t jlps_decode(input logic [3:0] sel);
      jlps_pkg::jlps_mode_t m;
      m = '0;
      m.valid = 1'b1;
      unique case (sel)
         4'h0: m[33:0] = {1'b0, 4'h9, 4'hc, 4'h8, 4'h8, 4'h8, 3'h5, 10'h100};
         4'h1: m[33:0] = {1'b0, 4'h9, 4'hc, 4'h6, 4'h4, 4'h2, 3'h2, 10'h140};
         4'h2: m[33:0] = {1'b0, 4'h8, 4'h8, 4'h4, 4'h4, 4'h1, 3'h1, 10'h140};
         4'h3: m[33:0] = {1'b0, 4'h9, 4'ha, 4'h4, 4'h4, 4'h5, 3'h4, 10'h190};
         4'h4: m[33:0] = {1'b1, 4'h9, 4'hc, 4'h3, 4'h4, 4'h2, 3'h1, 10'h210};
         4'h5: m[33:0] = {1'b1, 4'h8, 4'h8, 4'h2, 4'h4, 4'h2, 3'h1, 10'h210};
         4'h6: m[33:0] = {1'b1, 4'h9, 4'hc, 4'h6, 4'h4, 4'h2, 3'h2, 10'h108};
         4'h7: m[33:0] = {1'b1, 4'h8, 4'h8, 4'h4, 4'h4, 4'h1, 3'h1, 10'h108};
         4'h8: m[33:0] = {1'b1, 4'h9, 4'hc, 4'h4, 4'h4, 4'h3, 3'h2, 10'h18c};
         4'h9: m[33:0] = {1'b0, 4'h8, 4'h8, 4'h8, 4'h4, 4'h1, 3'h2, 10'h0a0};
         4'ha: m[33:0] = {1'b0, 4'h9, 4'ha, 4'h8, 4'h8, 4'h5, 3'h4, 10'h0c8};
         4'he: m[33:0] = {1'b1, 4'h9, 4'hc, 4'h8, 4'h8, 4'h3, 3'h2, 10'h0c6};
         default: m = '0;
      endcase
      return m;
   endfunction

   logic [7:0]  base_sum;
   logic [11:0] k64;

   always_comb begin
      d = q;
      d.cfg_ins = 1'b0;
      d.rdata = '0;
      base_sum = '0;
      k64 = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            `JLPS_OFS_CTRL: begin
               d.link_en = reg_wdata[`JLPS_CTRL_EN];
               d.scr_cfg = reg_wdata[`JLPS_CTRL_SCR];
            end
            `JLPS_OFS_MODE: d.link_operating_mode_select = reg_wdata[3:0];
            `JLPS_OFS_KM1: d.frames_per_multiframe_minus_one = reg_wdata[7:0];
            `JLPS_OFS_DID: d.did_cfg = reg_wdata[7:0];
            default: ;
         endcase
      end
      // Shadow set follows the user fields only while the link is down
      if (!q.link_en) begin
         d.act = jlps_decode(q.link_operating_mode_select);
         d.did = q.did_cfg;
         d.scr = q.scr_cfg;
         if (d.act.valid && d.act.enc64) begin
            k64 = (`JLPS_BLK_OCTETS * `JLPS_MB_BLOCKS * 12'(`JLPS_E_FIXED))
                  / 12'(d.act.octets);
            d.k = k64[8:0];
         end else begin
            d.k = 9'(q.frames_per_multiframe_minus_one) + 9'h001;
         end
         // Sum of the encoded octets; adjust, bank, CS, HD, CF, reserved are zero
         base_sum = d.did + 8'(d.scr) + 8'(d.act.lanes) - 8'h01
                  + 8'(d.act.octets) - 8'h01 + d.k[7:0] - 8'h01
                  + 8'(d.act.convs) - 8'h01 + 8'(d.act.n) - 8'h01
                  + 8'(d.act.nprime) - 8'h01 + 8'(d.act.samples) - 8'h01
                  + `JLPS_SUBCLASSV + `JLPS_JESDV + `JLPS_ZERO_FIELD;
         for (int i = 0; i < MAX_LANES; i++) begin
            d.chk[i] = base_sum + 8'(i);
            d.lane_en[i] = (i < int'(d.act.lanes));
         end
      end
      unique case (q.lst)
         jlps_pkg::JLPS_OFF: begin
            d.cnt = '0;
            if (q.link_en && q.act.valid) begin
               if (q.act.enc64) begin
                  d.lst = jlps_pkg::JLPS_DATA;
               end else if (!sync_req_n) begin
                  d.lst = jlps_pkg::JLPS_CGS;
               end
            end
         end
         jlps_pkg::JLPS_CGS: begin
            d.cnt = '0;
            if (sync_req_n) begin
               d.lst = jlps_pkg::JLPS_ILAS;
            end
         end
         jlps_pkg::JLPS_ILAS: begin
            d.cnt = q.cnt + 11'h001;
            // Parameter set rides in the second multiframe
            // Decided one frame early so the registered pulse lands on frame K
            // Suppressed when the sequence is cut by a sync request or disable
            d.cfg_ins = sync_req_n && q.link_en
                        && (q.cnt == 11'(q.k) - 11'h001);
            if (!sync_req_n) begin
               d.lst = jlps_pkg::JLPS_CGS;
            end else if (q.cnt == `JLPS_ILAS_MF * 11'(q.k) - 11'h001) begin
               d.lst = jlps_pkg::JLPS_DATA;
            end
         end
         jlps_pkg::JLPS_DATA: begin
            d.cnt = '0;
            if (!q.act.enc64 && !sync_req_n) begin
               d.lst = jlps_pkg::JLPS_CGS;
            end
         end
      endcase
      if (!q.link_en) begin
         d.lst = jlps_pkg::JLPS_OFF;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `JLPS_OFS_CTRL: d.rdata = {30'h0, q.scr_cfg, q.link_en};
            `JLPS_OFS_MODE: d.rdata = {28'h0, q.link_operating_mode_select};
            `JLPS_OFS_KM1: d.rdata = {24'h0, q.frames_per_multiframe_minus_one};
            `JLPS_OFS_DID: d.rdata = {24'h0, q.did_cfg};
            `JLPS_OFS_STATUS:
               d.rdata = {20'h0, q.act.lanes, 3'h0, q.act.enc64, q.lst,
                          1'b0, ~q.act.valid};
            `JLPS_OFS_PARAMA:
               d.rdata = {q.act.convs, q.act.lanes, q.act.octets, 1'b0,
                          q.act.samples, q.act.nprime, q.act.n, q.did};
            `JLPS_OFS_PARAMB:
               d.rdata = {15'h0, q.scr, `JLPS_E_FIXED, 3'h0, q.k};
            `JLPS_OFS_RATE: d.rdata = {22'h0, q.act.rate_x32};
            `JLPS_OFS_CHKSUM: d.rdata = {24'h0, q.chk[0]};
            default: d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.link_operating_mode_select <= `JLPS_RST_MODE;
         q.frames_per_multiframe_minus_one <= `JLPS_RST_KM1;
         q.did_cfg <= `JLPS_RST_DID;
         q.lst <= jlps_pkg::JLPS_OFF;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign ilas_active = (q.lst == jlps_pkg::JLPS_ILAS);
   assign cfg_insert = q.cfg_ins;
   assign data_active = (q.lst == jlps_pkg::JLPS_DATA);
   assign encoding_64b66b = q.act.enc64;
   assign serdes_rate_x32 = q.act.rate_x32;
   assign frames_per_mf = q.k;
   assign lane_enable = q.lane_en;

   for (genvar g = 0; g < MAX_LANES; g++) begin : g_lane
      assign lane_id[g*5 +: 5] = 5'(g);
      assign lane_chksum[g*8 +: 8] = q.chk[g];
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   freeze_set_a: assert property (q.link_en && $past(q.link_en) |-> $stable(q.act) && $stable(q.k))
      else $error("parameter set changed while link enabled");
   k_user_a: assert property (!q.link_en && !d.act.enc64 && d.act.valid
      |=> q.k == 9'($past(q.frames_per_multiframe_minus_one)) + 9'h001)
      else $error("K does not follow minus-one field");
   k_ext_a: assert property (!q.link_en && d.act.enc64 |=> q.k == 9'(12'h100 / 12'(q.act.octets)))
      else $error("64B/66B K not 256 over F");
   no_ilas64_a: assert property (q.act.enc64 |-> !ilas_active && q.lst != jlps_pkg::JLPS_CGS)
      else $error("ILAS or CGS in 64B/66B");
   sync_cgs_a: assert property (data_active && !q.act.enc64 && q.link_en && !sync_req_n
      |=> q.lst == jlps_pkg::JLPS_CGS)
      else $error("sync request did not restart CGS");
   cgs_ilas_a: assert property (q.lst == jlps_pkg::JLPS_CGS && sync_req_n && q.link_en
      |=> ilas_active ##1 (ilas_active || !q.link_en || !sync_req_n))
      else $error("ILAS did not follow CGS");
   ilas_end_a: assert property (ilas_active && sync_req_n && q.link_en
      && q.cnt == 11'h004 * 11'(q.k) - 11'h001 |=> data_active)
      else $error("ILAS length wrong");
   cfg_slot_a: assert property (cfg_insert |-> ilas_active && q.cnt == 11'(q.k))
      else $error("parameter set slot misplaced");
   // Reset values are all zero, so only a decoded set is checked
   chk_step_a: assert property (q.act.valid |-> lane_chksum[15:8] == lane_chksum[7:0] + 8'h01)
      else $error("lane checksum not offset by lane id");
   rate_m4_a: assert property (!q.link_en && q.link_operating_mode_select == 4'h4
      |=> serdes_rate_x32 == 10'h210)
      else $error("rate factor wrong for mode 4");
   unmapped_a: assert property (reg_rd && reg_addr > `JLPS_OFS_CHKSUM |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside read cycle");

   ilas_done_c: cover property (ilas_active ##1 data_active);
   data64_c: cover property (encoding_64b66b && data_active);
   cfg_slot_c: cover property (cfg_insert);
   resync_c: cover property (data_active && !q.act.enc64 ##1 q.lst == jlps_pkg::JLPS_CGS);
endmodule
`default_nettype wire

// ==== inc/jlps_defines.svh ====
`ifndef JLPS_DEFINES_SVH
`define JLPS_DEFINES_SVH
`define JLPS_OFS_CTRL    8'h00
`define JLPS_OFS_MODE    8'h04
`define JLPS_OFS_KM1     8'h08
`define JLPS_OFS_DID     8'h0c
`define JLPS_OFS_STATUS  8'h10
`define JLPS_OFS_PARAMA  8'h14
`define JLPS_OFS_PARAMB  8'h18
`define JLPS_OFS_RATE    8'h1c
`define JLPS_OFS_CHKSUM  8'h20
`define JLPS_CTRL_EN     0
`define JLPS_CTRL_SCR    1
`define JLPS_RST_MODE    4'h0
`define JLPS_RST_KM1     8'h1f
`define JLPS_RST_DID     8'h00
`define JLPS_E_FIXED     4'h1
`define JLPS_JESDV       8'h01
`define JLPS_SUBCLASSV   8'h01
`define JLPS_ZERO_FIELD  8'h00
`define JLPS_BLK_OCTETS  12'h008
`define JLPS_MB_BLOCKS   12'h020
`define JLPS_ILAS_MF     11'h004
`endif

// ==== inc/jlps_pkg.sv ====
package jlps_pkg;
   typedef enum logic [1:0] {
      JLPS_OFF  = 2'b00,
      JLPS_CGS  = 2'b01,
      JLPS_ILAS = 2'b10,
      JLPS_DATA = 2'b11
   } jlps_link_state_t;
   typedef struct packed {
      logic       valid;
      logic       enc64;
      logic [3:0] n;
      logic [3:0] nprime;
      logic [3:0] lanes;
      logic [3:0] convs;
      logic [3:0] octets;
      logic [2:0] samples;
      logic [9:0] rate_x32;
   } jlps_mode_t;
endpackage

// ==== bench/jlps_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module jlps_rx_model #(
   parameter int HOLD = 6
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic link_en,
   input  wire logic resync,
   output logic      sync_req_n
);
   int cnt;
   // Request sync, release after HOLD+1 cycles of link enable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_req_n <= 1'b0;
         cnt <= 0;
      end else if (resync) begin
         sync_req_n <= 1'b0;
         cnt <= 0;
      end else if (!sync_req_n && link_en) begin
         cnt <= cnt + 1;
         if (cnt == HOLD)
            sync_req_n <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== bench/tb_jlps_param_set.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_jlps_param_set;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        link_en = 1'b0;
   logic        resync = 1'b0;
   logic [31:0] reg_rdata, v;
   logic        sync_req_n, ilas_active, cfg_insert, data_active, enc64;
   logic [9:0]  rate;
   logic [8:0]  kfr, k;
   logic [7:0]  lane_en;
   logic [39:0] lane_id;
   logic [63:0] lane_ck;
   logic [43:0] m;
   int          n_mismatch = 0;
   int          checks = 0;
   int          n, pos, cfgs;
   // Mode, 64b flag, N, N', L, M, F, S, R times 32
   localparam logic [43:0] MODES [12] = '{44'h009c8885100, 44'h109c6422140,
      44'h20884411140, 44'h309a4454190, 44'h419c3421210, 44'h51882421210,
      44'h619c6422108, 44'h71884411108, 44'h819c443218c, 44'h908884120a0,
      44'ha09a88540c8, 44'he19c88320c6};
   always #2 clk = ~clk;
   jlps_param_set dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sync_req_n(sync_req_n), .ilas_active(ilas_active), .cfg_insert(cfg_insert),
      .data_active(data_active), .encoding_64b66b(enc64), .serdes_rate_x32(rate),
      .frames_per_mf(kfr), .lane_enable(lane_en), .lane_id(lane_id),
      .lane_chksum(lane_ck));
   jlps_rx_model rx (.clk(clk), .reset_n(reset_n), .link_en(link_en),
      .resync(resync), .sync_req_n(sync_req_n));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   task automatic wait_hi(input int sel);
      for (int i = 0; i < 200; i++) begin
         @(posedge clk);
         #1;
         if ((sel == 0 ? ilas_active : data_active) === 1'b1)
            return;
      end
      n_mismatch++;
      stop_test();
   endtask
   function automatic logic [7:0] cks(input logic [43:0] e, input logic [8:0] kk, input int lid);
      return 8'(e[35:32] + e[31:28] + e[27:24] + e[23:20] + e[19:16] + e[15:12] + kk - 7
                + 8'h5a + 3 + lid);
   endfunction
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h04); check("mode", v, 32'h0);
      rd(8'h08); check("km1", v, 32'h1f);
      rd(8'h24); check("unmapped", v, 32'h0);
      wr(8'h0c, 32'h5a);
      wr(8'h08, 32'h3f);
      wr(8'h00, 32'h2);
      foreach (MODES[i]) begin
         m = MODES[i];
         k = m[36] ? 9'(256 / m[19:16]) : 9'd64;
         wr(8'h04, 32'(m[43:40]));
         repeat (4) @(posedge clk);
         #1;
         check("enc", enc64, m[36]);
         check("rate", rate, m[9:0]);
         check("frames", kfr, k);
         check("lanes", lane_en, (1 << m[27:24]) - 1);
         for (int j = 0; j < 8; j++) begin
            check("lane id", lane_id[j*5+:5], j);
            check("lane cks", lane_ck[j*8+:8], cks(m, k, j));
         end
         rd(8'h14); check("param a", v, {m[23:20], m[27:24], m[19:16], 1'b0, m[14:12], m[31:28], m[35:32], 8'h5a});
         rd(8'h1c); check("rate reg", v, {22'h0, m[9:0]});
         rd(8'h20); check("chksum reg", v, {24'h0, cks(m, k, 0)});
         rd(8'h18); check("param b", v, {15'h0, 1'b1, 4'h1, 3'h0, k});
         rd(8'h10); check("status", v, {20'h0, m[27:24], 3'h0, m[36], 4'h0});
      end
      wr(8'h04, 32'hb);
      wr(8'h00, 32'h3);
      repeat (20) @(posedge clk);
      rd(8'h10); check("invalid", v[3:0], 4'h1);
      wr(8'h00, 32'h2);
      wr(8'h04, 32'h0);
      repeat (4) @(posedge clk);
      wr(8'h00, 32'h3);
      link_en <= 1'b1;
      wait_hi(0);
      n = 0;
      pos = 0;
      cfgs = 0;
      while (ilas_active === 1'b1 && n < 1000) begin
         if (cfg_insert === 1'b1) begin
            pos = n;
            cfgs++;
         end
         n++;
         @(posedge clk);
         #1;
      end
      check("ilas len", n, 256);
      check("cfg slot", pos, 64);
      check("cfg count", cfgs, 1);
      check("data", data_active, 1'b1);
      wr(8'h04, 32'h5);
      repeat (4) @(posedge clk);
      #1;
      check("frozen", enc64, 1'b0);
      @(posedge clk);
      resync <= 1'b1;
      @(posedge clk);
      resync <= 1'b0;
      wait_hi(0);
      check("resync", data_active, 1'b0);
      wr(8'h00, 32'h2);
      link_en <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("off", {ilas_active, data_active}, 2'b00);
      repeat (4) @(posedge clk);
      wr(8'h00, 32'h3);
      link_en <= 1'b1;
      wait_hi(1);
      check("no ilas", ilas_active, 1'b0);
      @(posedge clk);
      resync <= 1'b1;
      @(posedge clk);
      resync <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check("sync ign", data_active, 1'b1);
      stop_test();
   end
   initial begin
      #40000;
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
